/* File: logic/pcie_dma_traffic_monitor.sv */
module pcie_dma_traffic_monitor
    import traffic_monitor_pkg::*;
#(
    parameter int TICK_CYCLES = INTERVAL_CYCLES
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [NUM_ENGINES-1:0] eng_tvalid,
    input wire logic [NUM_ENGINES-1:0] eng_tready,
    input wire logic [NUM_ENGINES*KEEP_W-1:0] eng_tkeep,
    input wire logic tx_tvalid,
    input wire logic tx_tready,
    input wire logic tx_tlast,
    input wire logic [KEEP_W-1:0] tx_tkeep,
    input wire logic [DATA_W-1:0] tx_tdata,
    input wire logic rx_tvalid,
    input wire logic rx_tready,
    input wire logic rx_tlast,
    input wire logic [KEEP_W-1:0] rx_tkeep,
    input wire logic [DATA_W-1:0] rx_tdata,
    output logic [NUM_ENGINES*CNT_W-1:0] eng_byte_count,
    output logic [CNT_W-1:0] tx_all_count,
    output logic [CNT_W-1:0] rx_all_count,
    output logic [CNT_W-1:0] tx_payload_count,
    output logic [CNT_W-1:0] rx_payload_count,
    output logic interval_tick
);
    function automatic logic [BYTES_W-1:0] keep_bytes(input logic [KEEP_W-1:0] keep);
        logic [BYTES_W-1:0] n;
        n = '0;
        for (int i = 0; i < KEEP_W; i++) begin
            n = n + BYTES_W'(keep[i]);
        end
        return n;
    endfunction

    function automatic logic [BYTES_W-1:0] hdr_bytes(input logic [DATA_W-1:0] data);
        return data[FMT_LO] ? HDR_4DW_BYTES : HDR_3DW_BYTES;
    endfunction

    localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);

    logic [CNT_W-1:0] tmr_q;
    logic tick;
    logic tx_beat;
    logic rx_beat;
    logic tx_in_pkt_q;
    logic rx_in_pkt_q;
    logic tx_match_q;
    logic rx_match_q;
    logic tx_sop_match;
    logic rx_sop_match;
    logic [BYTES_W-1:0] tx_bytes;
    logic [BYTES_W-1:0] rx_bytes;
    logic [BYTES_W-1:0] tx_pay_bytes;
    logic [BYTES_W-1:0] rx_pay_bytes;
    logic tx_pay_valid;
    logic rx_pay_valid;

    // One-second interval timer
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tmr_q <= CNT_RESET;
        end else if (tick) begin
            tmr_q <= CNT_RESET;
        end else begin
            tmr_q <= tmr_q + CNT_W'(1);
        end
    end

    assign tick = (tmr_q == TICK_LAST);
    assign interval_tick = tick;

    assign tx_beat = tx_tvalid && tx_tready;
    assign rx_beat = rx_tvalid && rx_tready;
    assign tx_bytes = keep_bytes(tx_tkeep);
    assign rx_bytes = keep_bytes(rx_tkeep);

    // Packet framing: first accepted beat after tlast carries the header
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_in_pkt_q <= 1'b0;
        end else if (tx_beat) begin
            tx_in_pkt_q <= !tx_tlast;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_in_pkt_q <= 1'b0;
        end else if (rx_beat) begin
            rx_in_pkt_q <= !rx_tlast;
        end
    end

    // Memory write with data, either header size
    assign tx_sop_match = tx_tdata[FMT_HI] && (tx_tdata[TYPE_HI:TYPE_LO] == TYPE_MEM);
    // Completion with data
    assign rx_sop_match = (rx_tdata[FMT_HI:FMT_LO] == FMT_DATA_3DW)
                          && (rx_tdata[TYPE_HI:TYPE_LO] == TYPE_CPL);

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_match_q <= 1'b0;
        end else if (tx_beat && !tx_in_pkt_q) begin
            tx_match_q <= tx_sop_match;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rx_match_q <= 1'b0;
        end else if (rx_beat && !rx_in_pkt_q) begin
            rx_match_q <= rx_sop_match;
        end
    end

    // Header bytes of the first beat are stripped from the payload
    always_comb begin
        tx_pay_valid = 1'b0;
        tx_pay_bytes = '0;
        if (tx_beat && !tx_in_pkt_q) begin
            tx_pay_valid = tx_sop_match;
            if (tx_bytes > hdr_bytes(tx_tdata)) begin
                tx_pay_bytes = tx_bytes - hdr_bytes(tx_tdata);
            end
        end else if (tx_beat) begin
            tx_pay_valid = tx_match_q;
            tx_pay_bytes = tx_bytes;
        end
    end

    always_comb begin
        rx_pay_valid = 1'b0;
        rx_pay_bytes = '0;
        if (rx_beat && !rx_in_pkt_q) begin
            rx_pay_valid = rx_sop_match;
            if (rx_bytes > HDR_3DW_BYTES) begin
                rx_pay_bytes = rx_bytes - HDR_3DW_BYTES;
            end
        end else if (rx_beat) begin
            rx_pay_valid = rx_match_q;
            rx_pay_bytes = rx_bytes;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_ENGINES; g++) begin : g_eng
            // Only handshaken user-side beats count as delivered
            byte_accumulator u_eng_acc (
                .ref_clk(ref_clk),
                .reset_n(reset_n),
                .add_valid(eng_tvalid[g] && eng_tready[g]),
                .add_bytes(keep_bytes(eng_tkeep[g*KEEP_W +: KEEP_W])),
                .tick(tick),
                .total_q(eng_byte_count[g*CNT_W +: CNT_W])
            );
        end
    endgenerate

    byte_accumulator u_tx_all (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .add_valid(tx_beat),
        .add_bytes(tx_bytes),
        .tick(tick),
        .total_q(tx_all_count)
    );

    byte_accumulator u_rx_all (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .add_valid(rx_beat),
        .add_bytes(rx_bytes),
        .tick(tick),
        .total_q(rx_all_count)
    );

    byte_accumulator u_tx_pay (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .add_valid(tx_pay_valid),
        .add_bytes(tx_pay_bytes),
        .tick(tick),
        .total_q(tx_payload_count)
    );

    byte_accumulator u_rx_pay (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .add_valid(rx_pay_valid),
        .add_bytes(rx_pay_bytes),
        .tick(tick),
        .total_q(rx_payload_count)
    );

    property p_eng_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        !tick |=> $stable(eng_byte_count);
    endproperty
    a_eng_hold: assert property (p_eng_hold) else $error("engine count moved mid-interval");

    property p_tx_all;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && tx_beat |=> tx_all_count >= CNT_W'($past(tx_bytes));
    endproperty
    a_tx_all: assert property (p_tx_all) else $error("tx beat missing from total");

    property p_rx_all;
        @(posedge ref_clk) disable iff (!reset_n)
        tick && rx_beat |=> rx_all_count >= CNT_W'($past(rx_bytes));
    endproperty
    a_rx_all: assert property (p_rx_all) else $error("rx beat missing from total");

    property p_tx_pay;
        @(posedge ref_clk) disable iff (!reset_n)
        tx_payload_count <= tx_all_count;
    endproperty
    a_tx_pay: assert property (p_tx_pay) else $error("tx payload above total");

    property p_rx_pay;
        @(posedge ref_clk) disable iff (!reset_n)
        rx_payload_count <= rx_all_count;
    endproperty
    a_rx_pay: assert property (p_rx_pay) else $error("rx payload above total");

    property p_tick_restart;
        @(posedge ref_clk) disable iff (!reset_n)
        tick |=> tmr_q == CNT_RESET ##1 tmr_q == CNT_W'(1);
    endproperty
    a_tick_restart: assert property (p_tick_restart) else $error("interval timer slipped");

    property p_tx_hold;
        @(posedge ref_clk) disable iff (!reset_n)
        !tick |=> $stable(tx_all_count) && $stable(rx_payload_count);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("counter moved mid-interval");

    property p_cpl_pay;
        @(posedge ref_clk) disable iff (!reset_n)
        rx_beat && !rx_in_pkt_q && !rx_sop_match |-> !rx_pay_valid;
    endproperty
    a_cpl_pay: assert property (p_cpl_pay) else $error("non-completion counted");

    c_tick: cover property (@(posedge ref_clk) disable iff (!reset_n) tick);
    c_mwr: cover property (@(posedge ref_clk) disable iff (!reset_n) tx_pay_valid ##1 tx_pay_valid);
    c_cpl: cover property (@(posedge ref_clk) disable iff (!reset_n) rx_pay_valid && tick);
endmodule // pcie_dma_traffic_monitor

/* File: logic/traffic_monitor_pkg.sv */
package traffic_monitor_pkg;
    localparam int NUM_ENGINES = 4;
    localparam int BEAT_BYTES = 16;
    localparam int DATA_W = 128;
    localparam int KEEP_W = 16;
    localparam int CNT_W = 32;
    localparam int BYTES_W = 5;
    localparam int CLK_PERIOD_NS = 5;
    localparam int INTERVAL_NS = 1_000_000_000;
    localparam int INTERVAL_CYCLES = INTERVAL_NS / CLK_PERIOD_NS;
    // Header DW0 field positions of the first beat
    localparam int FMT_HI = 30;
    localparam int FMT_LO = 29;
    localparam int TYPE_HI = 28;
    localparam int TYPE_LO = 24;
    localparam logic [1:0] FMT_DATA_3DW = 2'h2;
    localparam logic [1:0] FMT_DATA_4DW = 2'h3;
    localparam logic [4:0] TYPE_MEM = 5'h00;
    localparam logic [4:0] TYPE_CPL = 5'h0a;
    localparam logic [BYTES_W-1:0] HDR_3DW_BYTES = 5'h0c;
    localparam logic [BYTES_W-1:0] HDR_4DW_BYTES = 5'h10;
    localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
endpackage

/* File: logic/byte_accumulator.sv */
module byte_accumulator
    import traffic_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic add_valid,
    input wire logic [BYTES_W-1:0] add_bytes,
    input wire logic tick,
    output logic [CNT_W-1:0] total_q
);
    logic [CNT_W-1:0] acc_q;
    logic [CNT_W-1:0] sum;

    // Current beat joins the closing interval so nothing falls between
    assign sum = add_valid ? acc_q + CNT_W'(add_bytes) : acc_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            acc_q <= CNT_RESET;
        end else if (tick) begin
            acc_q <= CNT_RESET;
        end else begin
            acc_q <= sum;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            total_q <= CNT_RESET;
        end else if (tick) begin
            total_q <= sum;
        end
    end

    property p_snapshot;
        @(posedge ref_clk) disable iff (!reset_n)
        tick |=> total_q == $past(sum);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("snapshot lost bytes");

    property p_restart;
        @(posedge ref_clk) disable iff (!reset_n)
        tick |=> acc_q == CNT_RESET;
    endproperty
    a_restart: assert property (p_restart) else $error("accumulator not restarted");
endmodule // byte_accumulator

/* File: verification/pcie_core_model.sv */
module pcie_core_model
    import traffic_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic slow,
    input wire logic rx_tready,
    output logic tx_tready,
    output logic rx_tvalid,
    output logic rx_tlast,
    output logic [KEEP_W-1:0] rx_tkeep,
    output logic [DATA_W-1:0] rx_tdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy = 1'b0;
    initial begin
        tx_tready = 1'b1;
        rx_tvalid = 1'b0;
        rx_tlast = 1'b0;
        rx_tkeep = 16'h0;
        rx_tdata = 128'h0;
    end
    // Slow mode stalls every other cycle, so some valid beats are not taken
    always @(posedge ref_clk) begin
        tx_tready <= slow ? ~tx_tready : 1'b1;
    end
    // Idle lines keep changing so a stale value never looks like a beat
    always @(posedge ref_clk) begin
        if (!busy) begin
            rx_tdata <= ~rx_tdata;
            rx_tkeep <= ~rx_tkeep;
        end
    end
    task automatic rx_beat(input logic [KEEP_W-1:0] k, input logic [31:0] dw, input logic l);
        if (!busy) begin
            busy = 1'b1;
            @(posedge ref_clk);
        end
        rx_tvalid <= 1'b1;
        rx_tkeep <= k;
        rx_tdata <= {4{dw}};
        rx_tlast <= l;
        do @(posedge ref_clk); while (rx_tready !== 1'b1);
        if (l) begin
            rx_tvalid <= 1'b0;
            busy = 1'b0;
        end
    endtask
endmodule // pcie_core_model

/* File: verification/pcie_dma_traffic_monitor_bench.sv */
module pcie_dma_traffic_monitor_bench
    import traffic_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICKS = 64;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic slow = 1'b1;
    logic [NUM_ENGINES-1:0] eng_tvalid = 4'h0;
    logic [NUM_ENGINES-1:0] eng_tready = 4'h0;
    logic [NUM_ENGINES*KEEP_W-1:0] eng_tkeep = 64'h0;
    logic tx_tvalid = 1'b0;
    logic tx_tlast = 1'b0;
    logic [KEEP_W-1:0] tx_tkeep = 16'h0;
    logic [DATA_W-1:0] tx_tdata = 128'h0;
    logic rx_tready = 1'b0;
    logic tx_tready;
    logic rx_tvalid;
    logic rx_tlast;
    logic [KEEP_W-1:0] rx_tkeep;
    logic [DATA_W-1:0] rx_tdata;
    logic [NUM_ENGINES*CNT_W-1:0] eng_byte_count;
    logic [CNT_W-1:0] tx_all_count;
    logic [CNT_W-1:0] rx_all_count;
    logic [CNT_W-1:0] tx_payload_count;
    logic [CNT_W-1:0] rx_payload_count;
    logic interval_tick;
    int n_errors = 0;
    int comparisons = 0;
    int n;

    always #2.5 ref_clk = ~ref_clk;

    pcie_dma_traffic_monitor #(.TICK_CYCLES(TICKS)) dut (.ref_clk(ref_clk), .reset_n(reset_n),
        .eng_tvalid(eng_tvalid), .eng_tready(eng_tready), .eng_tkeep(eng_tkeep),
        .tx_tvalid(tx_tvalid), .tx_tready(tx_tready), .tx_tlast(tx_tlast),
        .tx_tkeep(tx_tkeep), .tx_tdata(tx_tdata), .rx_tvalid(rx_tvalid),
        .rx_tready(rx_tready), .rx_tlast(rx_tlast), .rx_tkeep(rx_tkeep), .rx_tdata(rx_tdata),
        .eng_byte_count(eng_byte_count), .tx_all_count(tx_all_count),
        .rx_all_count(rx_all_count), .tx_payload_count(tx_payload_count),
        .rx_payload_count(rx_payload_count), .interval_tick(interval_tick));

    pcie_core_model core (.ref_clk(ref_clk), .slow(slow), .rx_tready(rx_tready),
        .tx_tready(tx_tready), .rx_tvalid(rx_tvalid), .rx_tlast(rx_tlast),
        .rx_tkeep(rx_tkeep), .rx_tdata(rx_tdata));

    task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Bounded so a dead timer still ends the run
    task automatic wait_tick(output int cnt);
        cnt = 0;
        do begin
            @(posedge ref_clk);
            cnt++;
        end while (interval_tick !== 1'b1 && cnt < 500);
        if (interval_tick !== 1'b1) begin
            n_errors++;
        end
        #1;
    endtask

    task automatic tx_beat(input logic [KEEP_W-1:0] k, input logic [31:0] dw, input logic l);
        tx_tvalid <= 1'b1;
        tx_tkeep <= k;
        tx_tdata <= {4{dw}};
        tx_tlast <= l;
        do @(posedge ref_clk); while (tx_tready !== 1'b1);
    endtask

    task automatic test_traffic;
        int c;
        @(posedge ref_clk);
        fork
            begin
                tx_beat(16'hffff, 32'h4000_0001, 1'b0);
                tx_beat(16'h00ff, 32'h0, 1'b1);
                tx_beat(16'h0fff, 32'h0000_0001, 1'b1);
                tx_beat(16'hffff, 32'h6000_0001, 1'b0);
                tx_beat(16'h000f, 32'h0, 1'b1);
                tx_tvalid <= 1'b0;
            end
            begin
                rx_tready <= 1'b1;
                core.rx_beat(16'hffff, 32'h4a00_0001, 1'b0);
                core.rx_beat(16'hffff, 32'h0, 1'b1);
                core.rx_beat(16'h0fff, 32'h0a00_0001, 1'b1);
                core.rx_beat(16'hffff, 32'h4000_0001, 1'b1);
            end
            begin
                eng_tvalid <= 4'hf;
                eng_tkeep <= 64'h000f_0007_0003_0001;
                @(posedge ref_clk);
                eng_tready <= 4'hf;
                repeat (2) @(posedge ref_clk);
                eng_tvalid <= 4'h0;
                eng_tready <= 4'h0;
            end
        join
        wait_tick(c);
        for (int g = 0; g < NUM_ENGINES; g++) begin
            check(eng_byte_count[g*CNT_W+:CNT_W], 32'(2 * (g + 1)));
        end
        check(tx_all_count, 32'h0000_0038);
        check(rx_all_count, 32'h0000_003c);
        check(tx_payload_count, 32'h0000_0010);
        check(rx_payload_count, 32'h0000_0014);
    endtask

    // Quiet interval must read back zero, not the old totals
    task automatic test_restart;
        int c;
        wait_tick(c);
        check(32'(c), 32'(TICKS));
        check(tx_all_count, 32'h0);
        check(rx_all_count, 32'h0);
        check(eng_byte_count[CNT_W-1:0], 32'h0);
        check(tx_payload_count | rx_payload_count, 32'h0);
    endtask

    // Steady beats across a tick: the tick-cycle beat goes to the closing interval
    task automatic test_boundary;
        int c;
        logic [CNT_W-1:0] part;
        @(posedge ref_clk);
        fork
            begin
                eng_tvalid <= 4'h1;
                eng_tready <= 4'h1;
                eng_tkeep <= 64'h0000_0000_0000_0001;
                repeat (100) @(posedge ref_clk);
                eng_tvalid <= 4'h0;
                eng_tready <= 4'h0;
            end
            begin
                wait_tick(c);
                part = eng_byte_count[CNT_W-1:0];
                wait_tick(c);
            end
        join
        check(part, 32'h0000_003f);
        check(part + eng_byte_count[CNT_W-1:0], 32'h0000_0064);
    endtask

    initial begin
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        wait_tick(n);
        test_traffic;
        test_restart;
        test_boundary;
        stop_test;
    end

    initial begin
        #20000;
        n_errors++;
        stop_test;
    end
endmodule // pcie_dma_traffic_monitor_bench
